/* design/acc_top.sv */
`timescale 1ns/100ps
// What this block does
// [RULE1] successive approximation yields a 10-bit code, zero is ground
// [RULE2] reference select connects supply, internal 2.56V, or external reference
// [RULE3] channel field picks input pin, ground, bandgap or a differential pair
// [RULE4] two differential pairs get gain of 1x, 10x or 200x
// [RULE5] single-ended selection bypasses the gain stage
// [RULE6] selections apply only while enabled; analog powered down when disabled
// [RULE7] software should disable the converter before sleeping
// [RULE8] result right adjusted by default, left adjusted when selected
// [RULE9] software reads low byte then high, or high only when left adjusted
// [RULE10] low byte read freezes results until high byte read; completions dropped
// [RULE11] every completion raises the done flag, even a dropped one
// [RULE12] writing start begins one conversion; bit clears when it ends
// [RULE13] channel change during a conversion waits until it ends
// [RULE14] auto trigger enable lets a selected trigger source start conversions
// [RULE15] trigger rising edge resets the prescaler and starts a conversion
// [RULE16] edges during a conversion ignored; level held high starts nothing
// [RULE17] a trigger flag must be cleared before it can trigger again
// [RULE18] done flag as trigger runs freely after a first software start
// [RULE19] start still works in auto mode; start bit reads one while busy
// [RULE20] conversion takes 13 converter cycles, first after enable takes 25
// [RULE21] prescaler counts only while enabled, held in reset otherwise
// [RULE22] completion writes result, sets flag, clears start in single mode
// [RULE23] done flag cleared by interrupt service or writing one
module acc_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt request and service acknowledge
  output logic irq,
  input wire logic irq_ack,
  // trigger sources from other peripherals, same clock
  input wire logic [7:1] trigger_in,
  // analog side
  output logic analog_power_enable,
  output logic [1:0] reference_select_out,
  output logic ref_connect_supply,
  output logic ref_connect_internal,
  output logic [4:0] channel_out,
  output logic gain_bypass,
  output acc_pkg::acc_gain_t gain_out,
  output logic sample_hold,
  output logic [9:0] dac_code,
  input wire logic comparator_in
);
  import acc_pkg::*;

  acc_core_if core ();

  acc_prescaler u_presc (
    .clock(clock),
    .reset_n(reset_n),
    .core(core)
  );

  acc_sar u_sar (
    .clock(clock),
    .reset_n(reset_n),
    .core(core)
  );

  // bus state
  logic pready_r, next_pready;
  logic pslverr_r, next_pslverr;
  logic [31:0] prdata_r, next_prdata;
  logic [31:0] rd_value;
  logic mapped;
  logic access, wr, rd;

  // control and sequencer state
  logic [7:0] sel_reg, next_sel_reg;
  logic enable, next_enable;
  logic auto_trig, next_auto_trig;
  logic ie, next_ie;
  logic [2:0] presc_sel, next_presc_sel;
  logic start_bit, next_start_bit;
  logic flag, next_flag;
  logic [2:0] trig_sel, next_trig_sel;
  logic [9:0] result, next_result;
  logic lock, next_lock;
  acc_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic first_pending, next_first_pending;
  logic conv_first, next_conv_first;
  logic [1:0] ref_lat, next_ref_lat;
  logic [4:0] chan_lat, next_chan_lat;
  logic bypass_r, next_bypass;
  acc_gain_t gain_r, next_gain;
  logic hold_r, next_hold;
  logic trig_prev, next_trig_prev;
  logic trig_level, trig_edge, wr_start, free_run;
  logic sar_start, sar_step, presc_restart;
  logic [4:0] samp;

  // transfer phases
  assign access = psel && penable;
  assign wr = access && pready_r && pwrite;
  assign rd = access && pready_r && !pwrite;

  // read mux with left or right adjusted result bytes
  always_comb begin
    rd_value = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      REG_INPUT_SEL: rd_value[7:0] = sel_reg;
      REG_CTRL_A: rd_value[7:0] = {enable, start_bit, auto_trig, flag, ie, presc_sel};
      REG_CTRL_B: rd_value[2:0] = trig_sel;
      REG_RESULT_LOW: rd_value[7:0] = sel_reg[SEL_LEFT_BIT] ?
        {result[1:0], 6'h00} : result[7:0]; // [RULE8]
      REG_RESULT_HIGH: rd_value[7:0] = sel_reg[SEL_LEFT_BIT] ?
        result[9:2] : {6'h00, result[9:8]}; // [RULE8] [RULE9]
      default: mapped = 1'b0;
    endcase
  end

  // one wait state, data and error captured in the first access cycle
  always_comb begin
    next_pready = access && !pready_r;
    next_pslverr = (access && !pready_r) ? !mapped : 1'b0;
    next_prdata = (access && !pready_r && !pwrite) ? rd_value : prdata_r;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= next_pready;
      pslverr_r <= next_pslverr;
      prdata_r <= next_prdata;
    end
  end

  // trigger choice, done flag stands in for the free-running source
  assign free_run = auto_trig && (trig_sel == TRIG_FREE_RUN); // [RULE18]
  assign trig_level = (trig_sel == TRIG_FREE_RUN) ? flag : trigger_in[trig_sel];
  assign wr_start = wr && (paddr == REG_CTRL_A) && pwdata[CA_START_BIT];
  assign samp = conv_first ? SAMPLE_FIRST : SAMPLE_NORMAL;
  assign trig_edge = auto_trig && (trig_sel != TRIG_FREE_RUN) &&
    trig_level && !trig_prev; // [RULE14] [RULE17]

  // register writes, flag and lock handling, conversion sequencer
  always_comb begin
    next_sel_reg = sel_reg;
    next_enable = enable;
    next_auto_trig = auto_trig;
    next_ie = ie;
    next_presc_sel = presc_sel;
    next_start_bit = start_bit;
    next_flag = flag;
    next_trig_sel = trig_sel;
    next_result = result;
    next_lock = lock;
    next_state = state;
    next_cnt = cnt;
    next_first_pending = first_pending;
    next_conv_first = conv_first;
    next_ref_lat = ref_lat;
    next_chan_lat = chan_lat;
    next_trig_prev = trig_level; // edge seen once, so a held level never re-fires [RULE16]
    sar_start = 1'b0;
    sar_step = 1'b0;
    presc_restart = 1'b0;
    if (wr && (paddr == REG_INPUT_SEL)) begin
      next_sel_reg = pwdata[7:0];
    end
    if (wr && (paddr == REG_CTRL_A)) begin
      next_enable = pwdata[CA_ENABLE_BIT];
      next_auto_trig = pwdata[CA_AUTO_BIT]; // [RULE14]
      next_ie = pwdata[CA_IE_BIT];
      next_presc_sel = pwdata[CA_PRESC_LSB +: 3];
    end
    if (wr && (paddr == REG_CTRL_B)) begin
      next_trig_sel = pwdata[CB_TRIG_LSB +: 3];
    end
    // low byte read freezes, high byte read releases
    if (rd && (paddr == REG_RESULT_LOW)) begin
      next_lock = 1'b1; // [RULE10]
    end
    if (rd && (paddr == REG_RESULT_HIGH)) begin
      next_lock = 1'b0; // [RULE10]
    end
    if (irq_ack || (wr && (paddr == REG_CTRL_A) && pwdata[CA_FLAG_BIT])) begin
      next_flag = 1'b0; // [RULE23]
    end
    if (core.sar_done) begin
      next_flag = 1'b1; // set wins over clear [RULE11] [RULE22] [RULE23]
      if (!lock) begin
        next_result = core.sar_result; // [RULE10] [RULE22]
      end
    end
    case (state)
      ST_IDLE: begin
        if (enable && (wr_start || trig_edge)) begin
          next_state = ST_WAIT;
          next_start_bit = 1'b1; // [RULE12] [RULE19]
          presc_restart = trig_edge; // [RULE15]
        end
      end
      ST_WAIT: begin
        if (core.tick) begin
          next_state = ST_CONV;
          next_cnt = 5'h00;
          sar_start = 1'b1;
          next_conv_first = first_pending; // [RULE20]
          next_first_pending = 1'b0;
        end
      end
      ST_CONV: begin
        if (core.tick) begin
          next_cnt = cnt + 5'h01;
          sar_step = (next_cnt > samp) && (next_cnt <= samp + SAR_STEPS); // [RULE20]
        end
        if (core.sar_done) begin
          if (free_run) begin
            next_state = ST_WAIT; // [RULE18]
          end else begin
            next_state = ST_IDLE;
            next_start_bit = 1'b0; // [RULE12] [RULE22]
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // selections track the register only between conversions
    if (enable && ((state == ST_IDLE) || core.sar_done)) begin
      next_ref_lat = sel_reg[SEL_REF_LSB +: 2]; // [RULE2] [RULE6] [RULE13]
      next_chan_lat = sel_reg[SEL_CHAN_LSB +: 5]; // [RULE3] [RULE6] [RULE13]
    end
    if (!enable) begin
      next_state = ST_IDLE; // [RULE6]
      next_start_bit = 1'b0;
      next_first_pending = 1'b1; // [RULE20]
    end
    next_bypass = acc_single_ended(next_chan_lat); // [RULE5]
    next_gain = acc_gain_of(next_chan_lat); // [RULE4]
    next_hold = (next_state == ST_CONV) && (next_cnt == (next_conv_first ?
      SAMPLE_FIRST : SAMPLE_NORMAL));
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sel_reg <= INPUT_SEL_RESET;
      enable <= CTRL_A_RESET[CA_ENABLE_BIT];
      auto_trig <= CTRL_A_RESET[CA_AUTO_BIT];
      ie <= CTRL_A_RESET[CA_IE_BIT];
      presc_sel <= CTRL_A_RESET[CA_PRESC_LSB +: 3];
      start_bit <= CTRL_A_RESET[CA_START_BIT];
      flag <= CTRL_A_RESET[CA_FLAG_BIT];
      trig_sel <= CTRL_B_RESET;
      result <= RESULT_RESET;
      lock <= 1'b0;
      state <= ST_IDLE;
      cnt <= 5'h00;
      first_pending <= 1'b1;
      conv_first <= 1'b0;
      ref_lat <= INPUT_SEL_RESET[SEL_REF_LSB +: 2];
      chan_lat <= INPUT_SEL_RESET[SEL_CHAN_LSB +: 5];
      bypass_r <= 1'b1;
      gain_r <= GAIN_1X;
      hold_r <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      sel_reg <= next_sel_reg;
      enable <= next_enable;
      auto_trig <= next_auto_trig;
      ie <= next_ie;
      presc_sel <= next_presc_sel;
      start_bit <= next_start_bit;
      flag <= next_flag;
      trig_sel <= next_trig_sel;
      result <= next_result;
      lock <= next_lock;
      state <= next_state;
      cnt <= next_cnt;
      first_pending <= next_first_pending;
      conv_first <= next_conv_first;
      ref_lat <= next_ref_lat;
      chan_lat <= next_chan_lat;
      bypass_r <= next_bypass;
      gain_r <= next_gain;
      hold_r <= next_hold;
      trig_prev <= next_trig_prev;
    end
  end

  // core link
  assign core.presc_enable = enable; // [RULE21]
  assign core.presc_restart = presc_restart;
  assign core.presc_sel = presc_sel;
  assign core.sar_start = sar_start;
  assign core.sar_step = sar_step;
  assign core.comparator_raw = comparator_in;

  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = flag && ie; // [RULE11]
  assign analog_power_enable = enable; // [RULE6]
  assign reference_select_out = ref_lat;
  assign ref_connect_supply = enable && (ref_lat == REF_SUPPLY); // [RULE2]
  assign ref_connect_internal = enable && (ref_lat == REF_INTERNAL); // [RULE2]
  assign channel_out = chan_lat;
  assign gain_bypass = bypass_r;
  assign gain_out = gain_r;
  assign sample_hold = hold_r;
  assign dac_code = core.dac_code;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_access;
    psel && penable && !pready_r;
  endsequence
  sequence s_free_done;
    core.sar_done && free_run && enable;
  endsequence
  sequence s_restart;
    (state == ST_WAIT) ##[1:128] (state == ST_CONV);
  endsequence

  a_apb_answer: assert property (s_access |=> pready_r)
    else $error("bus access not answered after one wait state");
  a_flag_on_done: assert property (core.sar_done |=> flag) // [RULE11]
    else $error("done flag not set on completion");
  a_flag_set_wins: assert property (core.sar_done && irq_ack |=> flag && irq == ie) // [RULE23]
    else $error("clear beat the completion");
  a_lock_holds: assert property (core.sar_done && lock |=> $stable(result)) // [RULE10]
    else $error("result changed while frozen");
  a_result_loads: assert property (core.sar_done && !lock |=>
    result == $past(core.sar_result)) // [RULE22]
    else $error("result not written on completion");
  a_conv_length: assert property (core.sar_done |->
    cnt == (conv_first ? FIRST_TICKS : NORMAL_TICKS) - 5'h01) // [RULE20]
    else $error("conversion length wrong");
  a_start_reads_busy: assert property (state != ST_IDLE |-> start_bit) // [RULE19]
    else $error("start bit low during conversion");
  a_single_clears: assert property (core.sar_done && !free_run |=>
    !start_bit && (state == ST_IDLE)) // [RULE12]
    else $error("single conversion did not end");
  a_free_restart: assert property (s_free_done |=> s_restart ##0 start_bit) // [RULE18]
    else $error("free run did not restart");
  a_edge_ignored: assert property ((state == ST_CONV) && trig_edge && !core.sar_done
    && enable |=> state == ST_CONV) // [RULE16]
    else $error("trigger edge disturbed a conversion");
  a_chan_frozen: assert property ((state == ST_CONV) && !core.sar_done |=>
    $stable(channel_out) && $stable(reference_select_out)) // [RULE13]
    else $error("selection changed mid conversion");
endmodule // acc_top

/* include/acc_pkg.sv */
package acc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] REG_INPUT_SEL = 8'h00;
  localparam logic [7:0] REG_CTRL_A = 8'h04;
  localparam logic [7:0] REG_CTRL_B = 8'h08;
  localparam logic [7:0] REG_RESULT_LOW = 8'h0C;
  localparam logic [7:0] REG_RESULT_HIGH = 8'h10;

  // input_selection_register fields
  localparam int SEL_REF_LSB = 6;
  localparam int SEL_LEFT_BIT = 5;
  localparam int SEL_CHAN_LSB = 0;

  // converter_control_status_a / _b fields
  localparam int CA_ENABLE_BIT = 7;
  localparam int CA_START_BIT = 6;
  localparam int CA_AUTO_BIT = 5;
  localparam int CA_FLAG_BIT = 4;
  localparam int CA_IE_BIT = 3;
  localparam int CA_PRESC_LSB = 0;
  localparam int CB_TRIG_LSB = 0;

  // reset values
  localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [2:0] CTRL_B_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // conversion timing in converter clock cycles
  localparam logic [4:0] NORMAL_TICKS = 5'h0D;
  localparam logic [4:0] FIRST_TICKS = 5'h19;
  localparam logic [4:0] SAMPLE_NORMAL = 5'h01;
  localparam logic [4:0] SAMPLE_FIRST = 5'h0D;
  localparam logic [4:0] SAR_STEPS = 5'h0B;
  localparam logic [3:0] SAR_IDLE_IDX = 4'hA;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [7:0] PRESC_MIN_DIV = 8'h04;

  // reference and channel codes
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  localparam logic [4:0] CH_SINGLE_LAST = 5'h07;
  localparam logic [4:0] CH_GAIN10_FIRST = 5'h08;
  localparam logic [4:0] CH_GAIN200_FIRST = 5'h0C;
  localparam logic [4:0] CH_GAIN_LAST = 5'h0F;
  localparam logic [4:0] CH_BANDGAP = 5'h1E;
  localparam logic [4:0] CH_GROUND = 5'h1F;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  typedef enum logic [1:0] {
    GAIN_1X = 2'b00,
    GAIN_10X = 2'b01,
    GAIN_200X = 2'b10
  } acc_gain_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } acc_state_t;

  // single-ended codes bypass the gain stage
  function automatic logic acc_single_ended(input logic [4:0] ch);
    return (ch <= CH_SINGLE_LAST) || (ch == CH_BANDGAP) || (ch == CH_GROUND);
  endfunction

  function automatic acc_gain_t acc_gain_of(input logic [4:0] ch);
    if (acc_single_ended(ch)) return GAIN_1X;
    if ((ch >= CH_GAIN200_FIRST) && (ch <= CH_GAIN_LAST)) return GAIN_200X;
    if (ch >= CH_GAIN10_FIRST && ch < CH_GAIN200_FIRST) return GAIN_10X;
    return GAIN_1X;
  endfunction

  // division ratio, floored so the comparator sync settles between ticks
  function automatic logic [7:0] acc_presc_div(input logic [2:0] sel);
    logic [7:0] d;
    d = 8'h01 << sel;
    return (d < PRESC_MIN_DIV) ? PRESC_MIN_DIV : d;
  endfunction
endpackage

/* include/acc_core_if.sv */
`timescale 1ns/100ps
interface acc_core_if;
  logic tick;
  logic presc_enable;
  logic presc_restart;
  logic [2:0] presc_sel;
  logic sar_start;
  logic sar_step;
  logic sar_done;
  logic [9:0] sar_result;
  logic [9:0] dac_code;
  logic comparator_raw;

  modport ctrl (
    output presc_enable, presc_restart, presc_sel, sar_start, sar_step, comparator_raw,
    input tick, sar_done, sar_result, dac_code
  );
  modport presc (
    input presc_enable, presc_restart, presc_sel,
    output tick
  );
  modport sar (
    input sar_start, sar_step, comparator_raw,
    output sar_done, sar_result, dac_code
  );
endinterface // acc_core_if

/* design/acc_prescaler.sv */
`timescale 1ns/100ps
module acc_prescaler (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link to the controller
  acc_core_if.presc core
);
  import acc_pkg::*;

  logic [7:0] count;
  logic [7:0] next_count;
  logic tick;
  logic next_tick;

  // divider held at zero while off, restarted by a trigger
  always_comb begin
    next_count = count + 8'h01;
    next_tick = 1'b0;
    if (!core.presc_enable || core.presc_restart) begin
      next_count = 8'h00; // [RULE21] [RULE15]
    end else if (count >= acc_presc_div(core.presc_sel) - 8'h01) begin
      next_count = 8'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign core.tick = tick;

  a_presc_held: assert property (@(posedge clock) disable iff (!reset_n)
    !core.presc_enable |=> (count == 8'h00) && !tick) // [RULE21]
    else $error("prescaler ran while converter off");
endmodule // acc_prescaler

/* design/acc_sar.sv */
`timescale 1ns/100ps
module acc_sar (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link to the controller
  acc_core_if.sar core
);
  import acc_pkg::*;

  logic cmp_meta;
  logic cmp_stable;
  logic [9:0] code;
  logic [9:0] next_code;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic done;
  logic next_done;
  logic [9:0] result;
  logic [9:0] next_result;
  logic [9:0] kept;

  // binary search, one bit decided per step, msb first
  always_comb begin
    next_code = code;
    next_idx = idx;
    next_done = 1'b0;
    next_result = result;
    kept = cmp_stable ? code : (code & ~(10'h001 << idx));
    if (core.sar_start) begin
      next_code = 10'h000;
      next_idx = SAR_IDLE_IDX;
    end else if (core.sar_step) begin
      if (idx == SAR_IDLE_IDX) begin
        next_code = SAR_MSB; // [RULE1]
        next_idx = 4'h9;
      end else if (idx == 4'h0) begin
        next_result = kept; // [RULE1]
        next_code = kept;
        next_done = 1'b1;
        next_idx = SAR_IDLE_IDX;
      end else begin
        next_code = kept | (10'h001 << (idx - 4'h1)); // [RULE1]
        next_idx = idx - 4'h1;
      end
    end
  end

  // comparator crosses from the analog side through two flops
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cmp_meta <= 1'b0;
      cmp_stable <= 1'b0;
      code <= 10'h000;
      idx <= SAR_IDLE_IDX;
      done <= 1'b0;
      result <= RESULT_RESET;
    end else begin
      cmp_meta <= core.comparator_raw;
      cmp_stable <= cmp_meta;
      code <= next_code;
      idx <= next_idx;
      done <= next_done;
      result <= next_result;
    end
  end

  assign core.dac_code = code;
  assign core.sar_done = done;
  assign core.sar_result = result;

  a_sar_last_bit: assert property (@(posedge clock) disable iff (!reset_n)
    core.sar_step && !core.sar_start && (idx == 4'h0) |=> done ##1 !done) // [RULE1]
    else $error("last bit did not end the search with one pulse");
endmodule // acc_sar

/* sim/acc_analog_model.sv */
`timescale 1ns/100ps
module acc_analog_model (
  // clock
  input wire logic clock,
  // level to convert and converter side
  input wire logic [9:0] target,
  input wire logic analog_power_enable,
  input wire logic [9:0] dac_code,
  // comparator answer
  output logic comparator_in
);
  logic toggle = 1'b0;
  // unpowered comparator gives no stable answer
  always_ff @(posedge clock) toggle <= ~toggle;
  // high while the input is at or above the trial code
  assign comparator_in = analog_power_enable ? (target >= dac_code) : toggle;
endmodule // acc_analog_model

/* sim/test_adc_conversion_control.sv */
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module test_adc_conversion_control;
  import acc_pkg::*;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, irq_ack = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, irq, analog_power_enable, ref_supply, ref_internal;
  logic gain_bypass, sample_hold, comparator_in;
  logic saw_hold = 1'b0;
  logic [7:1] trigger_in = 7'h00;
  logic [1:0] ref_out;
  logic [4:0] channel_out;
  acc_gain_t gain_out;
  logic [9:0] dac_code, target = 10'h000;
  int error_cnt = 0, checks_done = 0, cyc = 0, n;
  acc_top DUT (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .irq_ack(irq_ack), .trigger_in(trigger_in),
    .analog_power_enable(analog_power_enable), .reference_select_out(ref_out),
    .ref_connect_supply(ref_supply), .ref_connect_internal(ref_internal),
    .channel_out(channel_out), .gain_bypass(gain_bypass), .gain_out(gain_out),
    .sample_hold(sample_hold), .dac_code(dac_code), .comparator_in(comparator_in));
  acc_analog_model PARTNER (.clock(clock), .target(target),
    .analog_power_enable(analog_power_enable), .dac_code(dac_code),
    .comparator_in(comparator_in));
  // clock and hang guard
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (sample_hold === 1'b1) saw_hold <= 1'b1; // sampling pulse seen at least once
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles until the done interrupt shows, first look one edge after the call
  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (irq !== 1'b1 && n < 2000);
  endtask
  task automatic t_reset;
    apb(0, REG_INPUT_SEL, 0); `CHK("input_sel", 32'h0000_0000, rd)
    apb(0, REG_CTRL_A, 0); `CHK("ctrl_a", 32'h0000_0000, rd)
    apb(0, REG_CTRL_B, 0); `CHK("ctrl_b", 32'h0000_0000, rd)
    apb(0, 8'h14, 0); `CHK("pslverr", 1'b1, err)
    `CHK("power", 1'b0, analog_power_enable)
    $display("test reset done");
  endtask
  task automatic t_first;
    target <= 10'h2A5;
    apb(1, REG_CTRL_A, 32'h0000_0088);
    @(posedge clock); `CHK("power", 1'b1, analog_power_enable)
    apb(1, REG_CTRL_A, 32'h0000_00C8);
    wait_irq; `CHK("len_first", 1'b1, (n >= 99 && n <= 102))
    `CHK("hold_seen", 1'b1, saw_hold)
    apb(0, REG_CTRL_A, 0); `CHK("ctrl_a", 32'h0000_0098, rd)
    apb(0, REG_RESULT_LOW, 0); `CHK("low", 32'h0000_00A5, rd)
    apb(0, REG_RESULT_HIGH, 0); `CHK("high", 32'h0000_0002, rd)
    apb(1, REG_CTRL_A, 32'h0000_0088);
    @(posedge clock); `CHK("irq_w0", 1'b1, irq)
    apb(1, REG_CTRL_A, 32'h0000_0098);
    @(posedge clock); `CHK("irq_w1", 1'b0, irq)
    $display("test first done");
  endtask
  task automatic t_lock;
    apb(1, REG_INPUT_SEL, 32'h0000_0020);
    apb(0, REG_RESULT_LOW, 0); `CHK("low_left", 32'h0000_0040, rd)
    target <= 10'h155;
    apb(1, REG_CTRL_A, 32'h0000_00C8);
    apb(1, REG_INPUT_SEL, 32'h0000_00EA);
    repeat (2) @(posedge clock); `CHK("chan_busy", 5'h00, channel_out)
    wait_irq; `CHK("irq_lost", 1'b1, irq)
    apb(0, REG_RESULT_HIGH, 0); `CHK("high_kept", 32'h0000_00A9, rd)
    `CHK("chan", 5'h0A, channel_out)
    `CHK("gain", GAIN_10X, gain_out)
    `CHK("bypass", 1'b0, gain_bypass)
    `CHK("ref", 1'b1, ref_internal)
    `CHK("ref_code", 2'h3, ref_out)
    `CHK("ref_supply", 1'b0, ref_supply)
    @(posedge clock) irq_ack <= 1'b1;
    @(posedge clock) irq_ack <= 1'b0;
    @(posedge clock); `CHK("irq_ack", 1'b0, irq)
    apb(1, REG_INPUT_SEL, 32'h0000_0000);
    $display("test lock done");
  endtask
  task automatic t_trig;
    target <= 10'h3FF;
    apb(1, REG_CTRL_B, 32'h0000_0001);
    apb(1, REG_CTRL_A, 32'h0000_00A8);
    @(posedge clock) trigger_in[1] <= 1'b1;
    apb(0, REG_CTRL_A, 0); `CHK("busy", 1'b1, rd[6])
    @(posedge clock) trigger_in[1] <= 1'b0;
    @(posedge clock) trigger_in[1] <= 1'b1;
    wait_irq;
    apb(1, REG_CTRL_A, 32'h0000_00B8);
    repeat (100) @(posedge clock);
    `CHK("no_retrig", 1'b0, irq)
    trigger_in[1] <= 1'b0;
    apb(0, REG_RESULT_LOW, 0); `CHK("low_full", 32'h0000_00FF, rd)
    apb(0, REG_RESULT_HIGH, 0); `CHK("high_full", 32'h0000_0003, rd)
    $display("test trigger done");
  endtask
  task automatic t_free;
    apb(1, REG_CTRL_B, 32'h0000_0000);
    apb(1, REG_CTRL_A, 32'h0000_00E8);
    wait_irq; `CHK("len_norm", 1'b1, (n >= 51 && n <= 54))
    apb(1, REG_CTRL_A, 32'h0000_00B8);
    wait_irq; `CHK("free_run", 1'b1, (n < 60))
    apb(0, REG_CTRL_A, 0); `CHK("start_kept", 1'b1, rd[6])
    // service held across a completion: the set must still show for a cycle
    irq_ack <= 1'b1;
    repeat (2) @(posedge clock);
    wait_irq; `CHK("set_wins", 1'b1, irq)
    irq_ack <= 1'b0;
    apb(1, REG_CTRL_A, 32'h0000_0010);
    @(posedge clock); `CHK("power_off", 1'b0, analog_power_enable)
    apb(1, REG_CTRL_A, 32'h0000_0040);
    apb(0, REG_CTRL_A, 0); `CHK("start_off", 1'b0, rd[6])
    $display("test free run done");
  endtask
  // verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_first;
    t_lock;
    t_trig;
    t_free;
    results;
  end
endmodule // test_adc_conversion_control
